// ---- design/cphc_hold_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

module cphc_hold_ctrl #(
  parameter int DATA_W = cphc_pkg::CPHC_DATA_W
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire cphc_pkg::cphc_core_req_t core_req,
  input wire logic cop_busy_hold,
  input wire logic cop_reject,
  input wire logic [DATA_W-1:0] store_data_bus,
  output cphc_pkg::cphc_holds_t holds_q,
  output logic [DATA_W-1:0] store_data_q,
  output logic reject_trap_q,
  output logic decode_pending_q,
  output logic exec_pending_q
);
  import cphc_pkg::*;

  logic busy_for_d;
  logic busy_for_e;
  logic want_e;
  logic want_d;
  logic exec_stall_d;
  logic decode_stall_d;
  logic lsu_mem_hold_d;
  logic lsu_exec_hold_d;
  logic cancel_d;
  logic flush;

  // the coprocessor shares clk_sys and drives busy from a flop, so it is
  // read directly; a synchroniser here would break the lockstep timing
  assign flush = core_req.flush_req;

  // busy is honoured only when the matching stall is not already up
  assign busy_for_d = cop_busy_hold && !holds_q.decode_stall;
  assign busy_for_e = cop_busy_hold && !holds_q.execute_stall;

  // execute wants to stall now, or kept its wish pending under busy
  assign want_e = core_req.exec_hold || exec_pending_q;

  // decode wants to stall for itself now, or kept its wish pending under busy
  assign want_d = core_req.decode_hold || decode_pending_q;

  // only registered state and core causes feed the next holds; the busy
  // input merely gates them, and every output leaves through a flop
  assign exec_stall_d = !flush && want_e && !busy_for_e;

  // an execute stall always lands in decode too, even if busy blocks
  // decode's own cause
  assign decode_stall_d = !flush
    && (exec_stall_d || (want_d && !busy_for_d));

  assign lsu_mem_hold_d = core_req.lsu_mem_noadv
    || core_req.load_miss;

  // lsu execute hold covers its own cause, the memory hold, and the
  // execute stall whenever both pipelines still run in lockstep; flush
  // cannot drop it under a memory hold, which flush leaves standing
  assign lsu_exec_hold_d = lsu_mem_hold_d
    || (!flush && (core_req.lsu_exec_noadv
    || (core_req.lockstep && exec_stall_d)));

  // cancel is re-driven while busy holds the instruction, flush wins
  assign cancel_d = !flush && (core_req.cancel_req
    || (holds_q.cancel_one_instr && cop_busy_hold));

  // decode and execute stall registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      holds_q.decode_stall <= CPHC_HOLD_RST;
      holds_q.execute_stall <= CPHC_HOLD_RST;
    end else begin
      holds_q.decode_stall <= decode_stall_d;
      holds_q.execute_stall <= exec_stall_d;
    end
  end

  // a stall suppressed by busy is remembered (decode's only while exec_valid is set),
  // so the same instruction is still held once busy drops; flush throws the wish away
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      decode_pending_q <= CPHC_HOLD_RST;
      exec_pending_q <= CPHC_HOLD_RST;
    end else begin
      decode_pending_q <= !flush && want_d && busy_for_d
        && !core_req.exec_valid ? 1'b0 : !flush && want_d && busy_for_d;
      exec_pending_q <= !flush && want_e && busy_for_e;
    end
  end

  // load/store unit holds
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      holds_q.lsu_exec_hold <= CPHC_HOLD_RST;
      holds_q.lsu_mem_hold <= CPHC_HOLD_RST;
    end else begin
      holds_q.lsu_exec_hold <= lsu_exec_hold_d;
      holds_q.lsu_mem_hold <= lsu_mem_hold_d;
    end
  end

  // cancel and flush are both registered after execute
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      holds_q.cancel_one_instr <= CPHC_CANCEL_RST;
      holds_q.pipeline_flush <= CPHC_FLUSH_RST;
    end else begin
      holds_q.cancel_one_instr <= cancel_d;
      holds_q.pipeline_flush <= flush;
    end
  end

  // store data keeps tracking the bus while the lsu holds a store, so the
  // value present when the hold falls is the one the lsu uses
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      store_data_q <= CPHC_DATA_RST;
    end else if (holds_q.lsu_exec_hold && core_req.store_in_exec) begin
      store_data_q <= store_data_bus;
    end else if (!holds_q.lsu_exec_hold) begin
      store_data_q <= store_data_bus;
    end
  end

  // reject sampling lives in its own small module
  cphc_reject_sampler u_reject (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .cop_reject(cop_reject),
    .cop_busy_hold(cop_busy_hold),
    .execute_stall(holds_q.execute_stall),
    .lsu_exec_hold(holds_q.lsu_exec_hold),
    .cancel_one_instr(holds_q.cancel_one_instr),
    .pipeline_flush(holds_q.pipeline_flush),
    .exec_valid(core_req.exec_valid),
    .reject_trap_q(reject_trap_q)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_flush_raised;
    core_req.flush_req;
  endsequence

  sequence s_all_clear;
    !holds_q.decode_stall && !holds_q.execute_stall
      && !holds_q.cancel_one_instr
      && (holds_q.lsu_exec_hold == holds_q.lsu_mem_hold);
  endsequence

  a_mem_with_exec: assert property (
    holds_q.lsu_mem_hold |-> holds_q.lsu_exec_hold)
    else $error("lsu memory hold without lsu execute hold");

  a_mem_hold_cause: assert property (
    (core_req.lsu_mem_noadv || core_req.load_miss) |=> holds_q.lsu_mem_hold)
    else $error("lsu memory hold missed its cause");

  a_flush_priority: assert property (
    s_flush_raised |=> s_all_clear)
    else $error("flush did not override holds and cancel");

  a_lockstep_pair: assert property (
    (holds_q.execute_stall && $past(core_req.lockstep))
      |-> holds_q.lsu_exec_hold)
    else $error("execute stall in lockstep without lsu hold");

  a_estall_after_busy: assert property (
    (cop_busy_hold && !holds_q.execute_stall) |=> !holds_q.execute_stall)
    else $error("execute stall raised under busy hold");

  a_dstall_after_busy: assert property (
    (cop_busy_hold && !holds_q.decode_stall && !exec_stall_d)
      |=> !holds_q.decode_stall)
    else $error("decode stall raised under busy hold");

  a_estall_folded: assert property (
    holds_q.execute_stall |-> holds_q.decode_stall)
    else $error("execute stall not folded into decode stall");

  a_cancel_kept: assert property (
    (holds_q.cancel_one_instr && cop_busy_hold && !core_req.flush_req)
      |=> holds_q.cancel_one_instr)
    else $error("cancel dropped while busy hold active");

  a_store_kept: assert property (
    (holds_q.lsu_exec_hold && core_req.store_in_exec)
      |=> store_data_q == $past(store_data_bus))
    else $error("store data not captured under lsu hold");

  a_estall_resumes: assert property (
    (exec_pending_q && !cop_busy_hold && !core_req.flush_req)
      |=> holds_q.execute_stall)
    else $error("pending execute stall lost after busy");

endmodule

`default_nettype wire

// ---- design/cphc_pkg.sv ----
package cphc_pkg;

  // width of the store data path between coprocessors and the core
  localparam int CPHC_DATA_W = 64;

  // reset values of the registered hold, cancel, flush, reject trap and store data outputs
  localparam logic CPHC_HOLD_RST = 1'b0;
  localparam logic CPHC_CANCEL_RST = 1'b0;
  localparam logic CPHC_FLUSH_RST = 1'b0;
  localparam logic CPHC_TRAP_RST = 1'b0;
  localparam logic [CPHC_DATA_W-1:0] CPHC_DATA_RST = 64'h0000_0000_0000_0000;

  // stall, cancel and flush causes raised by the core's own pipeline
  typedef struct packed {
    logic decode_hold;    // internal_decode_hold: decode instr cannot move
    logic exec_hold;      // execute instr cannot move to memory
    logic lsu_exec_noadv; // cop load/store stuck in lsu execute
    logic lsu_mem_noadv;  // cop load stuck in lsu memory
    logic load_miss;      // load cache miss
    logic lockstep;       // alu and lsu pipelines in lockstep
    logic cancel_req;     // cancel the instr entering memory
    logic flush_req;      // flush memory-entry instr and all younger
    logic store_in_exec;  // cop_store_instr sits in cop execute
    logic exec_valid;     // a valid cop instr sits in execute
  } cphc_core_req_t;

  // registered hold outputs driven to every coprocessor
  typedef struct packed {
    logic decode_stall;
    logic execute_stall;
    logic lsu_exec_hold;
    logic lsu_mem_hold;
    logic cancel_one_instr;
    logic pipeline_flush;
  } cphc_holds_t;

endpackage

// ---- design/cphc_reject_sampler.sv ----
`timescale 1ns/1ps
`default_nettype none

// samples the wired-and reject level only once busy, the execute stall and the lsu execute hold have dropped
module cphc_reject_sampler (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cop_reject,
  input wire logic cop_busy_hold,
  input wire logic execute_stall,
  input wire logic lsu_exec_hold,
  input wire logic cancel_one_instr,
  input wire logic pipeline_flush,
  input wire logic exec_valid,
  output logic reject_trap_q
);
  import cphc_pkg::*;

  logic holds_clear;

  // busy, an execute stall or an lsu execute hold still up means the reject level may belong to a stale cycle
  assign holds_clear = !cop_busy_hold && !execute_stall && !lsu_exec_hold;

  // cancelled or flushed instructions never trap, whatever they reject
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reject_trap_q <= CPHC_TRAP_RST;
    end else begin
      reject_trap_q <= cop_reject && exec_valid && holds_clear
        && !cancel_one_instr && !pipeline_flush;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_reject_not_held: assert property (
    reject_trap_q |-> $past(!cop_busy_hold && !execute_stall))
    else $error("reject sampled while a hold was up");

  a_reject_not_cancel: assert property (
    cancel_one_instr |=> !reject_trap_q)
    else $error("reject taken for a cancelled instruction");

endmodule

`default_nettype wire

// ---- sim/cphc_cop_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// behavioural coprocessor: busy, reject and store data all leave flops
module cphc_cop_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic busy_req,
  input wire logic reject_req,
  input wire logic [63:0] data_req,
  output logic cop_busy_hold,
  output logic cop_reject,
  output logic [63:0] store_data_bus
);
  // never fed by incoming holds, so the two sides cannot lock up
  always_ff @(negedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cop_busy_hold <= 1'b0;
      cop_reject <= 1'b1;
      store_data_bus <= 64'h0;
    end else begin
      cop_busy_hold <= busy_req;
      cop_reject <= reject_req;
      store_data_bus <= data_req;
    end
  end
endmodule

`default_nettype wire

// ---- sim/cphc_hold_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module cphc_hold_ctrl_tb_top;
  import cphc_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic busy_req = 1'b0;
  logic reject_req = 1'b1;
  logic [63:0] data_req = 64'h0;
  logic [63:0] d = 64'h0;
  cphc_core_req_t req = '0;
  cphc_core_req_t prv;
  logic cop_busy_hold, cop_reject, reject_trap_q;
  logic decode_pending_q, exec_pending_q;
  logic [63:0] store_data_bus, store_data_q;
  logic [63:0] sd = 64'h0;
  cphc_holds_t holds_q;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;

  always #50 clk_sys = ~clk_sys;

  cphc_cop_model cphc_cop_model_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .busy_req(busy_req), .reject_req(reject_req), .data_req(data_req),
    .cop_busy_hold(cop_busy_hold), .cop_reject(cop_reject),
    .store_data_bus(store_data_bus));

  cphc_hold_ctrl cphc_hold_ctrl_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .core_req(req), .cop_busy_hold(cop_busy_hold), .cop_reject(cop_reject),
    .store_data_bus(store_data_bus), .holds_q(holds_q),
    .store_data_q(store_data_q), .reject_trap_q(reject_trap_q),
    .decode_pending_q(decode_pending_q), .exec_pending_q(exec_pending_q));

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // partner lines follow one cycle after the request
  task automatic cop(input logic b, input logic r);
    busy_req <= b;
    reject_req <= r;
    cyc(1);
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'h2E687561));
    cyc(5);
    arst_n <= 1'b1;
    cyc(2);
    // random cause mix with the coprocessor never busy; one coprocessor
    // only, so no multi-transfer flag or foreign busy hold ever appears
    // and the model has no load, cancel or freeze duties to act on
    repeat (80) begin
      prv = req;
      chk("store data", store_data_q, sd);
      if (prv.flush_req) begin
        chk("flush", holds_q.pipeline_flush, 1'b1);
        chk("flush wins", {holds_q.decode_stall, holds_q.execute_stall,
            holds_q.lsu_exec_hold, holds_q.cancel_one_instr},
            {2'h0, prv.lsu_mem_noadv | prv.load_miss, 1'b0});
      end else begin
        chk("exec stall", holds_q.execute_stall, prv.exec_hold);
        chk("dec stall", holds_q.decode_stall,
            prv.exec_hold | prv.decode_hold);
        chk("cancel", holds_q.cancel_one_instr, prv.cancel_req);
        chk("lsu exec", holds_q.lsu_exec_hold,
            prv.lsu_exec_noadv | prv.lsu_mem_noadv | prv.load_miss |
            (prv.exec_hold & prv.lockstep));
      end
      chk("lsu mem", holds_q.lsu_mem_hold,
          prv.lsu_mem_noadv | prv.load_miss);
      req = cphc_core_req_t'(10'($urandom));
      // the word now on the bus lands unless a hold freezes a non-store
      if (!(holds_q.lsu_exec_hold && !req.store_in_exec)) sd = d;
      d = {$urandom, $urandom};
      data_req <= d;
      cyc(1);
    end
    // stall wishes arriving behind an established busy hold
    req = '0;
    cop(1'b1, 1'b1);
    cyc(1);
    req.exec_hold = 1'b1;
    req.decode_hold = 1'b1;
    req.exec_valid = 1'b1;
    cyc(1);
    chk("exec pend", {holds_q.execute_stall, exec_pending_q}, 2'h1);
    chk("dec pend", {holds_q.decode_stall, decode_pending_q}, 2'h1);
    chk("trap busy", reject_trap_q, 1'b0);
    cop(1'b0, 1'b1);
    chk("exec wait", holds_q.execute_stall, 1'b0);
    cyc(1);
    chk("exec late", holds_q.execute_stall, 1'b1);
    chk("dec fold", holds_q.decode_stall, 1'b1);
    req.exec_hold = 1'b0;
    req.decode_hold = 1'b0;
    cyc(2);
    chk("trap free", reject_trap_q, 1'b1);
    // cancel held by busy, then a flush overriding both
    cop(1'b1, 1'b0);
    req.cancel_req = 1'b1;
    cyc(1);
    req.cancel_req = 1'b0;
    chk("cancel", holds_q.cancel_one_instr, 1'b1);
    cyc(1);
    chk("cancel held", holds_q.cancel_one_instr, 1'b1);
    req.flush_req = 1'b1;
    cyc(1);
    req.flush_req = 1'b0;
    chk("flush busy", {holds_q.pipeline_flush,
        holds_q.cancel_one_instr}, 2'h2);
    cop(1'b0, 1'b1);
    cyc(2);
    conclude();
  end
endmodule

`default_nettype wire
